// File: logic/pllcc_pkg.sv
// Shared constants and types of the PLL clock conditioning block
package pllcc_pkg;
  // Bit positions inside the pin synchroniser bank
  localparam int SYNC_W = 4;
  localparam int IDX_REF = 0;
  localparam int IDX_FB = 1;
  localparam int IDX_SLEEP = 2;
  localparam int IDX_ARST = 3;
  // Output source selection codes
  localparam logic [2:0] SRC_PLL = 3'h0;
  localparam logic [2:0] SRC_BYPASS = 3'h1;
  // Divider widths and half-step factor limits
  localparam int DIV_W = 5;
  localparam int TOT_W = 7;
  localparam logic [4:0] FAC_MIN = 5'h01;
  localparam logic [4:0] HALF_MAX = 5'h0e;
  // Loop model and delay line defaults
  localparam int PER_W = 10;
  localparam int PHASE_TOL = 2;
  localparam int PERIOD_TOL = 2;
  localparam int LOCK_EDGES = 4;
  localparam int LOCK_W = 3;
  localparam int DELAY_TAPS = 8;
  localparam int DSEL_W = 3;
  typedef enum logic [1:0] {
    PLLCC_UNLOCKED = 2'b00,
    PLLCC_ACQUIRE = 2'b01,
    PLLCC_LOCKED = 2'b10
  } pllcc_lock_e;
endpackage

// File: logic/pllcc_top.sv
// PLL clock conditioning block: loop model, output dividers, global muxes
// Summary of operation
// RULE1: Reference clock feeds loop and primary output
// RULE2: Divider sync reset on rise, bypass only
// RULE3: Driver holds sync reset low beforehand
// RULE4: With loop in use, internal sync reset
// RULE5: Half-step only when bypassed from oscillator
// RULE6: Half-step factors 1.5 through 14.5
// RULE7: Sleep disables loop, outputs held low
// RULE8: Lock asserts on steady-state lock
// RULE9: External feedback compared against reference
// RULE10: Three global muxes drive global outputs
// RULE11: Each mux: select, divider, delay
// RULE12: Core outputs use local routing
// RULE13: Reference comes from pins, core, oscillator; the code takes it from reference_clock_in_i only
// RULE14: Lock drops on sleep or lost lock
`timescale 1ns/1ps
module pllcc_top #(
  parameter int PER_W = pllcc_pkg::PER_W,
  parameter int PHASE_TOL = pllcc_pkg::PHASE_TOL,
  parameter int PERIOD_TOL = pllcc_pkg::PERIOD_TOL,
  parameter int LOCK_EDGES = pllcc_pkg::LOCK_EDGES,
  parameter int DELAY_TAPS = pllcc_pkg::DELAY_TAPS
) (
  input wire logic clk_i, // 40 MHz system clock
  input wire logic sys_rst_i, // Synchronous reset, high
  input wire logic reference_clock_in_i, // Reference clock pin
  input wire logic external_feedback_in_i, // External feedback pin
  input wire logic feedback_external_sel_i, // 1: compare external feedback
  input wire logic pll_sleep_n_i, // Power-down, low active
  input wire logic output_a_divider_sync_reset_i, // Divider A sync reset
  input wire logic output_a_half_step_divide_i, // Half-step divide for A
  input wire logic reference_from_rc_osc_i, // Reference is the RC oscillator
  input wire logic [2:0] output_a_source_select_i, // Source of output A
  input wire logic [2:0] output_b_source_select_i, // Source of output B
  input wire logic [2:0] output_c_source_select_i, // Source of output C
  input wire logic [4:0] output_a_divide_i, // Divide factor A
  input wire logic [4:0] output_b_divide_i, // Divide factor B
  input wire logic [4:0] output_c_divide_i, // Divide factor C
  input wire logic [2:0] output_a_delay_select_i, // Delay taps A
  input wire logic [2:0] output_b_delay_select_i, // Delay taps B
  input wire logic [2:0] output_c_delay_select_i, // Delay taps C
  output logic primary_global_clock_o, // Global mux 1
  output logic secondary1_global_clock_o, // Global mux 2
  output logic secondary2_global_clock_o, // Global mux 3
  output logic core1_local_clock_o, // Local copy of mux 2
  output logic core2_local_clock_o, // Local copy of mux 3
  output logic lock_o // Steady-state lock, high
);
  localparam int LOCK_W = pllcc_pkg::LOCK_W;

  // Pin synchronisers; first stage feeds only the second
  logic [pllcc_pkg::SYNC_W-1:0] sync_meta_reg;
  logic [pllcc_pkg::SYNC_W-1:0] sync_reg;
  logic [pllcc_pkg::SYNC_W-1:0] sync_prev_reg;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sync_meta_reg <= 4'h0;
      sync_reg <= 4'h0;
      sync_prev_reg <= 4'h0;
    end else begin
      sync_meta_reg <= {output_a_divider_sync_reset_i, pll_sleep_n_i,
                        external_feedback_in_i, reference_clock_in_i};
      sync_reg <= sync_meta_reg;
      sync_prev_reg <= sync_reg;
    end
  end

  logic ref_rise;
  logic arst_rise;
  logic asleep;
  assign ref_rise = sync_reg[pllcc_pkg::IDX_REF] & ~sync_prev_reg[pllcc_pkg::IDX_REF];
  assign arst_rise = sync_reg[pllcc_pkg::IDX_ARST] & ~sync_prev_reg[pllcc_pkg::IDX_ARST];
  assign asleep = ~sync_reg[pllcc_pkg::IDX_SLEEP];

  // Loop model: period meter, oscillator aligned to the reference, phase detector
  logic [PER_W-1:0] per_cnt_reg, per_cnt_next;
  logic [PER_W-1:0] period_reg, period_next;
  logic [PER_W-1:0] vco_cnt_reg, vco_cnt_next;
  logic [PER_W-1:0] phase_cnt_reg, phase_cnt_next;
  logic vco_clk_reg, vco_clk_next;
  logic fb_prev_reg, fb_prev_next;
  logic phase_ok_reg, phase_ok_next;
  logic [PER_W-1:0] new_period;
  logic [PER_W-1:0] period_diff;
  logic fb_level;
  logic fb_rise;
  logic edge_good;

  assign fb_level = feedback_external_sel_i ? sync_reg[pllcc_pkg::IDX_FB] : vco_clk_reg; // RULE9
  assign fb_rise = fb_level & ~fb_prev_reg;
  assign new_period = per_cnt_reg + PER_W'(1);
  assign period_diff = (new_period > period_reg) ? new_period - period_reg
                                                 : period_reg - new_period;
  assign edge_good = phase_ok_reg & (period_diff <= PER_W'(PERIOD_TOL)); // RULE8

  always_comb begin
    per_cnt_next = (&per_cnt_reg) ? per_cnt_reg : per_cnt_reg + PER_W'(1);
    phase_cnt_next = (&phase_cnt_reg) ? phase_cnt_reg : phase_cnt_reg + PER_W'(1);
    period_next = period_reg;
    vco_cnt_next = (vco_cnt_reg >= period_reg - PER_W'(1)) ? '0 : vco_cnt_reg + PER_W'(1);
    phase_ok_next = phase_ok_reg | (fb_rise & (phase_cnt_reg <= PER_W'(PHASE_TOL))); // RULE9
    fb_prev_next = fb_level;
    if (ref_rise) begin
      // Snapping the oscillator to the reference edge keeps it phase aligned
      per_cnt_next = '0;
      period_next = new_period; // RULE1
      vco_cnt_next = '0;
      phase_cnt_next = '0;
      phase_ok_next = fb_rise;
    end
    vco_clk_next = vco_cnt_next < (period_reg >> 1);
    if (asleep) begin // RULE7
      per_cnt_next = '0;
      period_next = '0;
      vco_cnt_next = '0;
      phase_cnt_next = '0;
      phase_ok_next = 1'b0;
      vco_clk_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      per_cnt_reg <= '0;
      period_reg <= '0;
      vco_cnt_reg <= '0;
      phase_cnt_reg <= '0;
      vco_clk_reg <= 1'b0;
      fb_prev_reg <= 1'b0;
      phase_ok_reg <= 1'b0;
    end else begin
      per_cnt_reg <= per_cnt_next;
      period_reg <= period_next;
      vco_cnt_reg <= vco_cnt_next;
      phase_cnt_reg <= phase_cnt_next;
      vco_clk_reg <= vco_clk_next;
      fb_prev_reg <= fb_prev_next;
      phase_ok_reg <= phase_ok_next;
    end
  end

  // Lock detector: several good reference edges in a row before lock
  pllcc_pkg::pllcc_lock_e lock_state_reg, lock_state_next;
  logic [LOCK_W-1:0] good_cnt_reg, good_cnt_next;
  logic lock_reg, lock_next;
  logic lock_rise;
  assign lock_rise = (lock_state_reg == pllcc_pkg::PLLCC_LOCKED) & ~lock_reg & ~asleep;

  always_comb begin
    lock_state_next = lock_state_reg;
    good_cnt_next = good_cnt_reg;
    case (lock_state_reg)
      pllcc_pkg::PLLCC_UNLOCKED: begin
        if (ref_rise && edge_good) begin
          lock_state_next = pllcc_pkg::PLLCC_ACQUIRE;
          good_cnt_next = LOCK_W'(1);
        end
      end
      pllcc_pkg::PLLCC_ACQUIRE: begin
        if (ref_rise && !edge_good) begin // RULE14
          lock_state_next = pllcc_pkg::PLLCC_UNLOCKED;
          good_cnt_next = '0;
        end else if (ref_rise && good_cnt_reg >= LOCK_W'(LOCK_EDGES - 1)) begin
          lock_state_next = pllcc_pkg::PLLCC_LOCKED; // RULE8
        end else if (ref_rise) begin
          good_cnt_next = good_cnt_reg + LOCK_W'(1);
        end
      end
      pllcc_pkg::PLLCC_LOCKED: begin
        if (ref_rise && !edge_good) begin // RULE14
          lock_state_next = pllcc_pkg::PLLCC_UNLOCKED;
          good_cnt_next = '0;
        end
      end
      default: begin
        lock_state_next = pllcc_pkg::PLLCC_UNLOCKED;
        good_cnt_next = '0;
      end
    endcase
    if (asleep) begin // RULE14
      lock_state_next = pllcc_pkg::PLLCC_UNLOCKED;
      good_cnt_next = '0;
    end
    lock_next = ~asleep & (lock_state_reg == pllcc_pkg::PLLCC_LOCKED);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      lock_state_reg <= pllcc_pkg::PLLCC_UNLOCKED;
      good_cnt_reg <= '0;
      lock_reg <= 1'b0;
    end else begin
      lock_state_reg <= lock_state_next;
      good_cnt_reg <= good_cnt_next;
      lock_reg <= lock_next;
    end
  end

  // Global mux channels: source select, divider, delay line
  logic [2:0] src_sel [3];
  logic [4:0] div_val [3];
  logic [2:0] dly_sel [3];
  wire [2:0] chan_clk_next;
  assign src_sel[0] = output_a_source_select_i;
  assign src_sel[1] = output_b_source_select_i;
  assign src_sel[2] = output_c_source_select_i;
  assign div_val[0] = output_a_divide_i;
  assign div_val[1] = output_b_divide_i;
  assign div_val[2] = output_c_divide_i;
  assign dly_sel[0] = output_a_delay_select_i;
  assign dly_sel[1] = output_b_delay_select_i;
  assign dly_sel[2] = output_c_delay_select_i;

  for (genvar ch = 0; ch < 3; ch++) begin : gen_ch
    localparam int TOT_W = pllcc_pkg::TOT_W;
    logic src_lvl;
    logic src_edge;
    logic half_ok;
    logic restart;
    logic div_clk;
    logic [4:0] fac;
    logic [TOT_W-1:0] total;
    logic src_prev_reg, src_prev_next;
    logic [TOT_W-1:0] cnt_reg, cnt_next;
    logic [DELAY_TAPS-1:0] dly_reg, dly_next;

    always_comb begin
      src_lvl = 1'b0;
      if (src_sel[ch] == pllcc_pkg::SRC_PLL) begin
        src_lvl = vco_clk_reg;
      end else if (src_sel[ch] == pllcc_pkg::SRC_BYPASS) begin
        src_lvl = sync_reg[pllcc_pkg::IDX_REF]; // RULE1
      end
      src_edge = src_lvl ^ src_prev_reg;
      // Half-step silently ignored outside oscillator bypass
      half_ok = (ch == 0) && output_a_half_step_divide_i && reference_from_rc_osc_i
                && (src_sel[ch] == pllcc_pkg::SRC_BYPASS); // RULE5
      fac = (div_val[ch] < pllcc_pkg::FAC_MIN) ? pllcc_pkg::FAC_MIN : div_val[ch];
      if (half_ok && fac > pllcc_pkg::HALF_MAX) begin
        fac = pllcc_pkg::HALF_MAX; // RULE6
      end
      // Counted in source half-periods so a half step is one extra half-period
      total = TOT_W'({fac, 1'b0}) + TOT_W'(half_ok); // RULE6
      restart = ((ch == 0) && src_sel[ch] == pllcc_pkg::SRC_BYPASS && arst_rise) // RULE2
                || (src_sel[ch] == pllcc_pkg::SRC_PLL && lock_rise); // RULE4
      cnt_next = cnt_reg;
      if (asleep || restart) begin
        cnt_next = '0;
      end else if (src_edge) begin
        cnt_next = (cnt_reg >= total - TOT_W'(1)) ? '0 : cnt_reg + TOT_W'(1);
      end
      div_clk = cnt_reg < (total >> 1);
      dly_next = asleep ? '0 : {dly_reg[DELAY_TAPS-2:0], div_clk}; // RULE11
      src_prev_next = src_lvl;
    end

    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        src_prev_reg <= 1'b0;
        cnt_reg <= '0;
        dly_reg <= '0;
      end else begin
        src_prev_reg <= src_prev_next;
        cnt_reg <= cnt_next;
        dly_reg <= dly_next;
      end
    end

    assign chan_clk_next[ch] = ~asleep & dly_reg[dly_sel[ch]]; // RULE7 RULE11
  end

  // Output stage
  logic [2:0] glob_clk_reg, glob_clk_next;
  logic [1:0] core_clk_reg, core_clk_next;
  always_comb begin
    glob_clk_next = chan_clk_next; // RULE10
    core_clk_next = chan_clk_next[2:1]; // RULE12
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      glob_clk_reg <= 3'h0;
      core_clk_reg <= 2'h0;
    end else begin
      glob_clk_reg <= glob_clk_next;
      core_clk_reg <= core_clk_next;
    end
  end
  assign primary_global_clock_o = glob_clk_reg[0];
  assign secondary1_global_clock_o = glob_clk_reg[1];
  assign secondary2_global_clock_o = glob_clk_reg[2];
  assign core1_local_clock_o = core_clk_reg[0];
  assign core2_local_clock_o = core_clk_reg[1];
  assign lock_o = lock_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_sleep_quiet: assert property (asleep |=> (glob_clk_reg == 3'h0 && core_clk_reg == 2'h0)) // RULE7
    else $error("clock output active while asleep");
  a_sleep_unlock: assert property (asleep |=> !lock_o) // RULE14
    else $error("lock high while asleep");
  a_lock_cause: assert property ($rose(lock_o) |-> $past(lock_state_reg) == pllcc_pkg::PLLCC_LOCKED) // RULE8
    else $error("lock rose without locked state");
  a_lock_loss: assert property ((lock_state_reg == pllcc_pkg::PLLCC_LOCKED && ref_rise // RULE14
      && !edge_good && !asleep) |=> ##1 !lock_o)
    else $error("lock held after bad edge");
  a_ext_compare: assert property ((feedback_external_sel_i && ref_rise && !phase_ok_reg // RULE9
      && !asleep) |=> lock_state_reg == pllcc_pkg::PLLCC_UNLOCKED)
    else $error("missing feedback edge not seen");
  a_ref_source: assert property ((src_sel[0] == pllcc_pkg::SRC_BYPASS) // RULE1
      |-> gen_ch[0].src_lvl == sync_reg[pllcc_pkg::IDX_REF])
    else $error("output A not from reference");
  a_div_sync: assert property ((src_sel[0] == pllcc_pkg::SRC_BYPASS && arst_rise && !asleep) // RULE2
      |=> gen_ch[0].cnt_reg == 7'h00)
    else $error("divider A not resynchronised");
  a_pll_ignore: assert property ((src_sel[0] == pllcc_pkg::SRC_PLL && arst_rise && !lock_rise // RULE4
      && !asleep && !gen_ch[0].src_edge) |=> $stable(gen_ch[0].cnt_reg))
    else $error("external reset acted with loop in use");
  a_half_gate: assert property (!gen_ch[0].half_ok |-> !gen_ch[0].total[0]) // RULE5
    else $error("half step outside bypass");
  a_half_range: assert property (gen_ch[0].half_ok // RULE6
      |-> (gen_ch[0].total >= 7'h03 && gen_ch[0].total <= 7'h1d))
    else $error("half step factor out of range");
  a_core_tie: assert property (core1_local_clock_o == secondary1_global_clock_o // RULE12
      && core2_local_clock_o == secondary2_global_clock_o)
    else $error("core output differs from global");
  a_delay_path: assert property ((!asleep && $stable(output_b_delay_select_i)) // RULE10 RULE11
      |=> secondary1_global_clock_o == $past(gen_ch[1].dly_reg[output_b_delay_select_i]))
    else $error("global mux 2 delay tap wrong");

  c_lock_gain: cover property ($rose(lock_o));
  c_half_step: cover property (gen_ch[0].half_ok && gen_ch[0].src_edge);
  c_sleep_wake: cover property (asleep ##1 !asleep);
  c_sync_reset: cover property (arst_rise && src_sel[0] == pllcc_pkg::SRC_BYPASS);
endmodule

// File: test/pllcc_far.sv
// Far-side model: reference source, external feedback and divider resync driver
`timescale 1ns/1ps
module pllcc_far (
  input wire logic clk_i, // System clock
  input wire logic [7:0] half_period_i, // Reference half period in clk cycles
  input wire logic fb_en_i, // Return the reference as external feedback
  input wire logic sync_req_i, // Request one divider resync pulse
  output logic reference_clock_in_o, // Reference clock pin
  output logic external_feedback_in_o, // External feedback pin
  output logic sync_reset_o // Divider A resync pin
);
  logic [7:0] cnt_reg = 8'h00;
  logic [7:0] wait_reg = 8'h00;
  logic armed_reg = 1'b0;
  logic flip;
  initial begin
    reference_clock_in_o = 1'b0;
    external_feedback_in_o = 1'b0;
    sync_reset_o = 1'b0;
  end
  assign flip = (cnt_reg + 8'h01 >= half_period_i);
  always @(posedge clk_i) begin
    cnt_reg <= flip ? 8'h00 : cnt_reg + 8'h01;
    if (flip) begin
      reference_clock_in_o <= ~reference_clock_in_o;
    end
    // One cycle late keeps it inside the phase window; low when absent
    external_feedback_in_o <= fb_en_i & reference_clock_in_o;
    if (sync_req_i) begin
      armed_reg <= 1'b1;
      wait_reg <= 8'h28;
    end else if (wait_reg != 8'h00) begin
      wait_reg <= wait_reg - 8'h01;
    end
    // Low for over a source cycle first; rise lands on a reference edge
    if (armed_reg && wait_reg == 8'h00 && flip) begin
      sync_reset_o <= 1'b1;
      armed_reg <= 1'b0;
      wait_reg <= 8'h08;
    end else if (sync_reset_o && wait_reg == 8'h00) begin
      sync_reset_o <= 1'b0;
    end
  end
endmodule

// File: test/pll_clock_conditioning_macro_test.sv
// Self-checking testbench of the PLL clock conditioning block
`timescale 1ns/1ps
module pll_clock_conditioning_macro_test;
  localparam logic [2:0] BYP = pllcc_pkg::SRC_BYPASS;
  localparam logic [2:0] LOOP = pllcc_pkg::SRC_PLL;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic fb_sel = 1'b0, sleep_n = 1'b1, hs = 1'b0, rc = 1'b0, sync_req = 1'b0, fb_en = 1'b0;
  logic [2:0] sa = 3'h0, sb = 3'h0, sc = 3'h0, dly = 3'h0;
  logic [4:0] na = 5'h01, nb = 5'h01, nc = 5'h01;
  logic [7:0] half = 8'h06;
  wire refc, efb, srst, ga, gb, gc, y1, y2, lk;
  wire [4:0] outs = {y2, y1, gc, gb, ga};
  wire [7:0] mon = {srst, lk, refc, outs};
  int failures = 0;
  int n_compared = 0;
  always #12.5 clk_i = ~clk_i;
  pllcc_far far (.clk_i(clk_i), .half_period_i(half), .fb_en_i(fb_en), .sync_req_i(sync_req),
    .reference_clock_in_o(refc), .external_feedback_in_o(efb), .sync_reset_o(srst));
  pllcc_top uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reference_clock_in_i(refc),
    .external_feedback_in_i(efb), .feedback_external_sel_i(fb_sel), .pll_sleep_n_i(sleep_n),
    .output_a_divider_sync_reset_i(srst), .output_a_half_step_divide_i(hs),
    .reference_from_rc_osc_i(rc), .output_a_source_select_i(sa), .output_b_source_select_i(sb),
    .output_c_source_select_i(sc), .output_a_divide_i(na), .output_b_divide_i(nb),
    .output_c_divide_i(nc), .output_a_delay_select_i(dly), .output_b_delay_select_i(dly),
    .output_c_delay_select_i(dly), .primary_global_clock_o(ga), .secondary1_global_clock_o(gb),
    .secondary2_global_clock_o(gc), .core1_local_clock_o(y1), .core2_local_clock_o(y2),
    .lock_o(lk));
  task automatic summarize();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %0d seen %0d", name, exp, seen);
    end
  endtask
  // Window edges may cut one rise, so one off still counts as a match
  function automatic int near(input int seen, input int exp);
    return (seen - exp <= 1 && exp - seen <= 1) ? exp : seen;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wait_val(input int idx, input logic v, input int bound, output int n);
    n = 0;
    while (mon[idx] !== v) begin
      cyc(1);
      n++;
      if (n > bound) begin
        $display("[ERR] wait on monitor bit %0d timed out", idx);
        failures++;
        summarize();
      end
    end
  endtask
  task automatic cfg(input logic [2:0] a, b, c, input logic [4:0] xa, xb, xc, input logic [2:0] d);
    @(posedge clk_i);
    sa <= a;
    sb <= b;
    sc <= c;
    na <= xa;
    nb <= xb;
    nc <= xc;
    dly <= d;
    cyc(30);
  endtask
  task automatic measure(input int ntog, output int r [5]);
    logic [4:0] p;
    logic pr;
    int t;
    t = 0;
    r = '{0, 0, 0, 0, 0};
    p = outs;
    pr = refc;
    while (t < ntog) begin
      cyc(1);
      if (refc !== pr) t++;
      for (int k = 0; k < 5; k++) if (outs[k] === 1'b1 && p[k] === 1'b0) r[k]++;
      p = outs;
      pr = refc;
    end
  endtask
  task automatic t_bypass();
    int r [5];
    cfg(BYP, BYP, BYP, 5'h01, 5'h02, 5'h00, 3'h0);
    measure(60, r);
    check("a rises", near(r[0], 30), 30);
    check("b rises", near(r[1], 15), 15);
    check("c rises", near(r[2], 30), 30);
    check("y1 rises", near(r[3], 15), 15);
    check("y2 rises", near(r[4], 30), 30);
  endtask
  task automatic t_codes();
    int r [5];
    for (int c = 2; c < 8; c++) begin
      cfg(c[2:0], c[2:0], c[2:0], 5'h01, 5'h01, 5'h01, 3'h0);
      measure(12, r);
      check("idle rises", r[0] + r[1] + r[2] + r[3] + r[4], 0);
    end
  endtask
  task automatic lat(input logic [2:0] d, output int n);
    int w;
    cfg(BYP, BYP, BYP, 5'h01, 5'h01, 5'h01, d);
    wait_val(5, ~mon[5], 30, w);
    wait_val(0, ~mon[0], 30, n);
  endtask
  task automatic t_delay();
    int n0, n4;
    @(posedge clk_i);
    half <= 8'h0c;
    lat(3'h0, n0);
    lat(3'h4, n4);
    check("delay taps", n4 - n0, 4);
  endtask
  task automatic sync_pulse(output int t);
    int w1, w2;
    @(posedge clk_i);
    sync_req <= 1'b1;
    @(posedge clk_i);
    sync_req <= 1'b0;
    cyc(1);
    wait_val(7, 1'b1, 100, w1);
    // Past the resync and delay pipeline before timing the next rise
    cyc(12);
    wait_val(0, 1'b0, 120, w1);
    wait_val(0, 1'b1, 120, w2);
    t = w1 + w2;
  endtask
  task automatic t_sync();
    int a, b;
    @(posedge clk_i);
    half <= 8'h06;
    cfg(BYP, BYP, BYP, 5'h04, 5'h01, 5'h01, 3'h0);
    sync_pulse(a);
    cyc(23);
    sync_pulse(b);
    check("resync phase", b, a);
  endtask
  task automatic t_lock();
    int w;
    cfg(LOOP, LOOP, LOOP, 5'h01, 5'h01, 5'h01, 3'h0);
    wait_val(6, 1'b1, 400, w);
    check("lock", lk, 1'b1);
    @(posedge clk_i);
    fb_sel <= 1'b1;
    wait_val(6, 1'b0, 100, w);
    check("lock no feedback", lk, 1'b0);
    @(posedge clk_i);
    fb_en <= 1'b1;
    wait_val(6, 1'b1, 400, w);
    check("lock ext feedback", lk, 1'b1);
    @(posedge clk_i);
    half <= 8'h0a;
    wait_val(6, 1'b0, 100, w);
    check("lock lost", lk, 1'b0);
    wait_val(6, 1'b1, 400, w);
    check("relock", lk, 1'b1);
  endtask
  task automatic hs_case(input logic [2:0] s, input logic osc, input logic [4:0] n,
      input int ntog, input int exp);
    int r [5];
    @(posedge clk_i);
    hs <= 1'b1;
    rc <= osc;
    cfg(s, BYP, BYP, n, 5'h01, 5'h01, 3'h0);
    measure(ntog, r);
    check("half step rises", near(r[0], exp), exp);
  endtask
  task automatic t_half();
    hs_case(LOOP, 1'b1, 5'h01, 60, 30);
    hs_case(BYP, 1'b0, 5'h01, 60, 30);
    hs_case(BYP, 1'b1, 5'h01, 60, 20);
    hs_case(BYP, 1'b1, 5'h0e, 1740, 60);
  endtask
  task automatic t_sleep();
    logic any;
    int w;
    cfg(BYP, BYP, BYP, 5'h01, 5'h01, 5'h01, 3'h0);
    @(posedge clk_i);
    sleep_n <= 1'b0;
    cyc(5);
    any = 1'b0;
    repeat (40) begin
      any = any | (outs !== 5'h00);
      cyc(1);
    end
    check("sleep outputs", any, 1'b0);
    check("sleep lock", lk, 1'b0);
    @(posedge clk_i);
    sleep_n <= 1'b1;
    wait_val(0, 1'b1, 80, w);
  endtask
  initial begin
    cyc(19);
    check("reset outputs", {lk, outs}, 6'h00);
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    cyc(10);
    t_bypass();
    t_codes();
    t_delay();
    t_sync();
    t_lock();
    t_half();
    t_sleep();
    summarize();
  end
endmodule
